//--- dv/pic_cpu_model.sv
// Processor model driving the byte-wide I/O port
`default_nettype none
module pic_cpu_model (
    input wire logic core_clk,
    output logic [7:0] io_addr,
    output logic [7:0] io_wdata,
    output logic io_wr_n,
    output logic io_rd_n,
    input wire logic [7:0] io_rdata_reg,
    input wire logic io_rdata_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        io_addr = 8'h00;
        io_wdata = 8'h00;
        io_wr_n = 1'b1;
        io_rd_n = 1'b1;
    end
    // Address and data settle before the strobe and outlast it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        io_addr <= a;
        io_wdata <= d;
        repeat (3) @(posedge core_clk);
        io_wr_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        io_wr_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        io_addr <= ~a;
        io_wdata <= ~d;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
        output logic oe);
        io_addr <= a;
        repeat (3) @(posedge core_clk);
        io_rd_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        d = io_rdata_reg;
        oe = io_rdata_oe;
        io_rd_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        io_addr <= ~a;
        repeat (2) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

//--- dv/pic_interval_timer_tb_top.sv
// Self-checking bench for the interval timer
`include "pic_timer_defs.vh"
`default_nettype none
module pic_interval_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] cnt_clk_in = 3'h0;
    wire [7:0] io_addr, io_wdata, io_rdata_reg;
    wire io_wr_n, io_rd_n, io_rdata_oe;
    wire [2:0] cnt_out;
    logic [7:0] lo, hi;
    logic oe;
    int seed = 38;
    int num_errors = 0;
    int checks = 0;
    int n, m, n2;
    logic [7:0] ctl [6] = '{8'h14, 8'h36, 8'h76, 8'h64, 8'h37, 8'hb5};
    logic [15:0] val [6] = '{16'h0100, 16'h0004, 16'h0005, 16'h0009,
        16'h0015, 16'h0012};
    int ntab [6] = '{256, 4, 5, 9, 15, 12};
    pic_cpu_model cpu_u (.core_clk(core_clk), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr_n(io_wr_n), .io_rd_n(io_rd_n),
        .io_rdata_reg(io_rdata_reg), .io_rdata_oe(io_rdata_oe));
    pic_interval_timer dut_u (.core_clk(core_clk), .rst(rst),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr_n(io_wr_n),
        .io_rd_n(io_rd_n), .io_rdata_reg(io_rdata_reg),
        .io_rdata_oe(io_rdata_oe), .cnt_clk_in(cnt_clk_in),
        .cnt_out(cnt_out));
    always #2.5 core_clk = ~core_clk;
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] exp_lows(input bit sq, input int k);
        return sq ? 16'(2 * (k / 2)) : 16'h0002;
    endfunction
    // Control word, then LSB and/or MSB as the format asks
    task automatic prog(input logic [7:0] c, input logic [15:0] v);
        logic [7:0] a;
        a = `PIC_ADDR_CNT0 + {6'h00, c[7:6]};
        cpu_u.wr(`PIC_ADDR_CTRL, c);
        if (c[5]) cpu_u.wr(a, v[7:0]);
        if (c[4]) cpu_u.wr(a, v[15:8]);
    endtask
    // Each pulse is a rising then a falling input clock edge
    task automatic pulse(input int i, input int k);
        repeat (k) begin
            cnt_clk_in[i] <= 1'b1;
            repeat (8) @(posedge core_clk);
            cnt_clk_in[i] <= 1'b0;
            repeat (8) @(posedge core_clk);
        end
    endtask
    // Low samples over two periods, after a warm-up
    task automatic measure(input int i, input bit sq, input int k,
        input int warm);
        logic [15:0] lows;
        lows = 16'h0000;
        pulse(i, warm);
        repeat (2 * k) begin
            pulse(i, 1);
            if (cnt_out[i] === 1'b0) lows++;
        end
        cmp(lows, exp_lows(sq, k));
    endtask
    task automatic stop_test;
        $display("Checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        cmp(16'(cnt_out), 16'h0007);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int k = 0; k < 6; k++) begin
            prog(ctl[k], val[k]);
            measure(ctl[k][7:6], ctl[k][1], ntab[k], 2);
        end
        cpu_u.wr(`PIC_ADDR_CTRL, 8'hf6);
        measure(2, 1'b0, 12, 2);
        cpu_u.rd(`PIC_ADDR_CTRL, lo, oe);
        cmp(16'(oe), 16'h0000);
        repeat (3) begin
            n = 3 + {$random(seed)} % 20;
            m = {$random(seed)} % (2 * n);
            prog(8'hb4, 16'(n));
            pulse(2, 1 + m);
            cpu_u.wr(`PIC_ADDR_CTRL, 8'h80);
            cpu_u.rd(`PIC_ADDR_CNT2, lo, oe);
            cmp(16'(oe), 16'h0001);
            cpu_u.rd(`PIC_ADDR_CNT2, hi, oe);
            cmp({hi, lo}, 16'(n - m % n));
            n2 = 3 + {$random(seed)} % 20;
            cpu_u.wr(`PIC_ADDR_CNT2, 8'(n2));
            cpu_u.wr(`PIC_ADDR_CNT2, 8'h00);
            measure(2, 1'b0, n2, n + 2);
        end
        stop_test();
    end
endmodule
bind pic_interval_timer pic_timer_assertions chk_u (.core_clk(core_clk),
    .rst(rst), .io_addr(io_addr), .io_rd_n(io_rd_n),
    .io_rdata_oe(io_rdata_oe), .cnt_clk_in(cnt_clk_in), .cnt_out(cnt_out));
`default_nettype wire

//--- dv/pic_timer_assertions.sv
// Port-level checks for the interval timer
`include "pic_timer_defs.vh"
`default_nettype none
module pic_timer_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] io_addr,
    input wire logic io_rd_n,
    input wire logic io_rdata_oe,
    input wire logic [2:0] cnt_clk_in,
    input wire logic [2:0] cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence rd_start;
        $fell(io_rd_n) && io_addr[7:2] == 6'h30
            && io_addr != `PIC_ADDR_CTRL;
    endsequence
    sequence oe_late;
        ##1 !io_rdata_oe ##1 io_rdata_oe;
    endsequence
    chk_oe_rise: assert property (rd_start |-> oe_late)
        else $error("read enable timing wrong");
    chk_oe_drop: assert property ($rose(io_rd_n) |-> ##2 !io_rdata_oe)
        else $error("read enable not dropped");
    chk_oe_cause: assert property (io_rdata_oe |-> !$past(io_rd_n, 2))
        else $error("read enable without read");
    chk_ctrl_unread: assert property (
        io_rdata_oe |-> $past(io_addr, 2) != `PIC_ADDR_CTRL)
        else $error("control port answered a read");
    chk_oe_hold: assert property (
        io_rdata_oe && !io_rd_n |=> io_rdata_oe)
        else $error("read enable dropped early");
    chk_out0_fall: assert property (
        $fell(cnt_out[0]) |-> !$past(cnt_clk_in[0]))
        else $error("output 0 fell off a falling edge");
    chk_out1_fall: assert property (
        $fell(cnt_out[1]) |-> !$past(cnt_clk_in[1]))
        else $error("output 1 fell off a falling edge");
    chk_out2_fall: assert property (
        $fell(cnt_out[2]) |-> !$past(cnt_clk_in[2]))
        else $error("output 2 fell off a falling edge");
endmodule
`default_nettype wire

//--- hdl/pic_interval_timer.v
// Three-counter programmable interval timer with byte-wide I/O port
`include "pic_timer_defs.vh"
`default_nettype none

// Operation
// - Control words are written at port C3 and go to the selected counter.
// - Bits 7:6 pick counter 0, 1 or 2; code 11 is illegal.
// - Bits 5:4: latch, MSB only, LSB only, or LSB then MSB.
// - Bits 3:1: 010 rate generator, 011 square wave; others unused.
// - Bit 0 picks binary or four-digit BCD down-counting.
// - New count enters after all bytes plus a rising then falling clock.
// - Rate generator divides by N, output low one clock per N.
// - Rate generator count rewrite takes effect from the next period.
// - Square wave even count steps by two, half high half low.
// - Square wave at terminal count toggles output and reloads count.
// - Odd count, output high: first step one, then two until timeout.
// - Odd count, low phase: first step three, then two until timeout.
// - Odd count N: high (N+1)/2 clocks, low (N-1)/2 clocks.
module pic_interval_timer (
    input wire core_clk,
    input wire rst,
    input wire [7:0] io_addr,
    input wire [7:0] io_wdata,
    input wire io_wr_n,
    input wire io_rd_n,
    output reg [7:0] io_rdata_reg,
    output wire io_rdata_oe,
    input wire [2:0] cnt_clk_in,
    output wire [2:0] cnt_out
);

// Down-count by step in binary or BCD
function [15:0] pic_sub;
    input [15:0] v;
    input [1:0] step;
    input bcd;
    integer k;
    reg [4:0] d;
    reg [3:0] b;
    begin
        pic_sub = v - {14'h0, step};
        if (bcd) begin
            b = {2'b00, step};
            for (k = 0; k < 4; k = k + 1) begin
                d = {1'b0, v[k*4 +: 4]} - {1'b0, b};
                if (d[4]) begin
                    pic_sub[k*4 +: 4] = d[3:0] + 4'ha;
                    b = 4'h1;
                end else begin
                    pic_sub[k*4 +: 4] = d[3:0];
                    b = 4'h0;
                end
            end
        end
    end
endfunction

wire [`PIC_SYNC_W-1:0] sync_w;
wire [7:0] s_addr;
wire [7:0] s_wdata;
wire s_wr_n;
wire s_rd_n;
wire [2:0] s_cclk;

pic_sync #(
    .WIDTH(`PIC_SYNC_W),
    .RST_VAL(`PIC_SYNC_RST)
) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({io_addr, io_wdata, io_wr_n, io_rd_n, cnt_clk_in}),
    .sync_out(sync_w)
);

assign {s_addr, s_wdata, s_wr_n, s_rd_n, s_cclk} = sync_w;

reg wr_n_d_reg;
reg rd_n_d_reg;
reg [2:0] cclk_d_reg;
reg [7:0] wr_addr_reg;
reg [7:0] wr_data_reg;
reg [7:0] rd_addr_reg;

// Write acts at the end of the strobe on the held address and data
wire wr_take = s_wr_n & ~wr_n_d_reg;
wire rd_end = s_rd_n & ~rd_n_d_reg;
wire [2:0] cclk_rise = s_cclk & ~cclk_d_reg;
wire [2:0] cclk_fall = ~s_cclk & cclk_d_reg;
wire [23:0] rd_bytes;
wire ctrl_wr = wr_take && (wr_addr_reg == `PIC_ADDR_CTRL);
wire [1:0] ctrl_sel = wr_data_reg[`PIC_SEL_HI:`PIC_SEL_LO];
wire [1:0] ctrl_fmt = wr_data_reg[`PIC_FMT_HI:`PIC_FMT_LO];
wire [2:0] ctrl_mode = wr_data_reg[`PIC_MODE_HI:`PIC_MODE_LO];

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        wr_n_d_reg <= 1'b1;
        rd_n_d_reg <= 1'b1;
        cclk_d_reg <= 3'h0;
        wr_addr_reg <= `PIC_RST_BYTE;
        wr_data_reg <= `PIC_RST_BYTE;
        rd_addr_reg <= `PIC_RST_BYTE;
    end else begin
        wr_n_d_reg <= s_wr_n;
        rd_n_d_reg <= s_rd_n;
        cclk_d_reg <= s_cclk;
        if (!s_wr_n) begin
            wr_addr_reg <= s_addr;
            wr_data_reg <= s_wdata;
        end
        if (!s_rd_n) begin
            rd_addr_reg <= s_addr;
        end
    end
end

genvar i;
generate
for (i = 0; i < 3; i = i + 1) begin : g_cnt
    localparam [7:0] ADDR = (i == 0) ? `PIC_ADDR_CNT0 :
        (i == 1) ? `PIC_ADDR_CNT1 : `PIC_ADDR_CNT2;
    localparam [1:0] SEL = (i == 0) ? `PIC_SEL_CNT0 :
        (i == 1) ? `PIC_SEL_CNT1 : `PIC_SEL_CNT2;

    reg [2:0] mode_reg;
    reg bcd_reg;
    reg [1:0] fmt_reg;
    reg [15:0] count_reg;
    reg [15:0] stage_reg;
    reg msb_next_reg;
    reg pend_reg;
    reg rise_seen_reg;
    reg run_reg;
    reg [15:0] ce_reg;
    reg first_reg;
    reg out_reg;
    reg [15:0] latch_reg;
    reg latched_reg;
    reg rd_msb_reg;

    wire mode_ok = (mode_reg == `PIC_MODE_RATE) ||
        (mode_reg == `PIC_MODE_SQUARE);
    wire [15:0] ce_dec1 = pic_sub(ce_reg, `PIC_STEP_ONE, bcd_reg);
    // Odd count: high phase starts with one, low phase with three
    wire [1:0] sq_step = (count_reg[0] && first_reg) ?
        (out_reg ? `PIC_STEP_ONE : `PIC_STEP_THREE) :
        `PIC_STEP_TWO;
    wire [15:0] ce_sq = pic_sub(ce_reg, sq_step, bcd_reg);
    wire [15:0] rd_val = latched_reg ? latch_reg : ce_reg;
    wire cnt_wr = wr_take && (wr_addr_reg == ADDR);
    wire sel_hit = ctrl_wr && (ctrl_sel == SEL);

    assign cnt_out[i] = out_reg;
    assign rd_bytes[i*8 +: 8] = (fmt_reg == `PIC_FMT_MSB) ? rd_val[15:8] :
        (fmt_reg == `PIC_FMT_BOTH && rd_msb_reg) ? rd_val[15:8] :
        rd_val[7:0];

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= `PIC_RST_MODE;
            bcd_reg <= 1'b0;
            fmt_reg <= `PIC_RST_FMT;
            count_reg <= `PIC_RST_COUNT;
            stage_reg <= `PIC_RST_COUNT;
            msb_next_reg <= 1'b0;
            pend_reg <= 1'b0;
            rise_seen_reg <= 1'b0;
            run_reg <= 1'b0;
            ce_reg <= `PIC_RST_COUNT;
            first_reg <= 1'b0;
            out_reg <= 1'b1;
            latch_reg <= `PIC_RST_COUNT;
            latched_reg <= 1'b0;
            rd_msb_reg <= 1'b0;
        end else begin
            if (cclk_rise[i] && pend_reg) begin
                rise_seen_reg <= 1'b1;
            end
            if (cclk_fall[i]) begin
                if (pend_reg && rise_seen_reg) begin
                    // Count register takes the new value
                    count_reg <= stage_reg;
                    pend_reg <= 1'b0;
                    rise_seen_reg <= 1'b0;
                end
                // A running counter keeps counting through the transfer
                if (pend_reg && rise_seen_reg && !run_reg && mode_ok) begin
                    ce_reg <= stage_reg;
                    run_reg <= 1'b1;
                    first_reg <= 1'b1;
                    out_reg <= 1'b1;
                end else if (run_reg && mode_reg == `PIC_MODE_RATE) begin
                    if (ce_reg == `PIC_ONE) begin
                        ce_reg <= count_reg;
                        out_reg <= 1'b1;
                    end else begin
                        ce_reg <= ce_dec1;
                        out_reg <= (ce_dec1 != `PIC_ONE);
                    end
                end else if (run_reg) begin
                    if (ce_reg == {14'h0, sq_step}) begin
                        ce_reg <= count_reg;
                        out_reg <= ~out_reg;
                        first_reg <= 1'b1;
                    end else begin
                        ce_reg <= ce_sq;
                        first_reg <= 1'b0;
                    end
                end
            end
            if (sel_hit && ctrl_fmt == `PIC_FMT_LATCH) begin
                if (!latched_reg) begin
                    latch_reg <= ce_reg;
                    latched_reg <= 1'b1;
                    rd_msb_reg <= 1'b0;
                end
            end else if (sel_hit) begin
                // New configuration stops the counter until a count arrives
                mode_reg <= ctrl_mode;
                bcd_reg <= wr_data_reg[`PIC_BCD_BIT];
                fmt_reg <= ctrl_fmt;
                msb_next_reg <= 1'b0;
                pend_reg <= 1'b0;
                rise_seen_reg <= 1'b0;
                run_reg <= 1'b0;
                out_reg <= 1'b1;
                latched_reg <= 1'b0;
                rd_msb_reg <= 1'b0;
            end else if (cnt_wr) begin
                case (fmt_reg)
                    `PIC_FMT_MSB: begin
                        stage_reg <= {wr_data_reg, `PIC_RST_BYTE};
                        pend_reg <= 1'b1;
                        rise_seen_reg <= 1'b0;
                    end
                    `PIC_FMT_LSB: begin
                        stage_reg <= {`PIC_RST_BYTE, wr_data_reg};
                        pend_reg <= 1'b1;
                        rise_seen_reg <= 1'b0;
                    end
                    default: begin
                        if (!msb_next_reg) begin
                            stage_reg[7:0] <= wr_data_reg;
                            msb_next_reg <= 1'b1;
                        end else begin
                            stage_reg[15:8] <= wr_data_reg;
                            msb_next_reg <= 1'b0;
                            pend_reg <= 1'b1;
                            rise_seen_reg <= 1'b0;
                        end
                    end
                endcase
            end
            if (rd_end && rd_addr_reg == ADDR) begin
                if (fmt_reg == `PIC_FMT_BOTH) begin
                    rd_msb_reg <= ~rd_msb_reg;
                end
                if ((fmt_reg != `PIC_FMT_BOTH || rd_msb_reg) &&
                        !(sel_hit && ctrl_fmt == `PIC_FMT_LATCH)) begin
                    latched_reg <= 1'b0;
                end
            end
        end
    end
end
endgenerate

// Read data follows the addressed counter while the read strobe is low
assign io_rdata_oe = !s_rd_n && (s_addr == `PIC_ADDR_CNT0 ||
    s_addr == `PIC_ADDR_CNT1 || s_addr == `PIC_ADDR_CNT2);

always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        io_rdata_reg <= `PIC_RST_BYTE;
    end else if (!s_rd_n) begin
        case (s_addr)
            `PIC_ADDR_CNT0: io_rdata_reg <= rd_bytes[7:0];
            `PIC_ADDR_CNT1: io_rdata_reg <= rd_bytes[15:8];
            `PIC_ADDR_CNT2: io_rdata_reg <= rd_bytes[23:16];
            default: io_rdata_reg <= `PIC_RST_BYTE;
        endcase
    end
end

endmodule
`default_nettype wire

//--- hdl/pic_sync.v
// Two-flop synchroniser for the block's asynchronous pins
`default_nettype none

module pic_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire core_clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;

// The first stage feeds only the second stage
always @(posedge core_clk or posedge rst) begin
    if (rst) begin
        meta_reg <= RST_VAL;
        sync_reg <= RST_VAL;
    end else begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end
end

assign sync_out = sync_reg;

endmodule
`default_nettype wire

//--- hdl/pic_timer_defs.vh
// Constants for the programmable interval counter block
`ifndef PIC_TIMER_DEFS_VH
`define PIC_TIMER_DEFS_VH

// I/O port addresses
`define PIC_ADDR_CNT0 8'hc0
`define PIC_ADDR_CNT1 8'hc1
`define PIC_ADDR_CNT2 8'hc2
`define PIC_ADDR_CTRL 8'hc3

// Control word field positions
`define PIC_SEL_HI 7
`define PIC_SEL_LO 6
`define PIC_FMT_HI 5
`define PIC_FMT_LO 4
`define PIC_MODE_HI 3
`define PIC_MODE_LO 1
`define PIC_BCD_BIT 0

// counter_select codes
`define PIC_SEL_CNT0 2'h0
`define PIC_SEL_CNT1 2'h1
`define PIC_SEL_CNT2 2'h2
`define PIC_SEL_ILLEGAL 2'h3

// access_format codes
`define PIC_FMT_LATCH 2'h0
`define PIC_FMT_MSB 2'h1
`define PIC_FMT_LSB 2'h2
`define PIC_FMT_BOTH 2'h3

// count_mode_field codes
`define PIC_MODE_RATE 3'h2
`define PIC_MODE_SQUARE 3'h3

// Decrement steps
`define PIC_STEP_ONE 2'h1
`define PIC_STEP_TWO 2'h2
`define PIC_STEP_THREE 2'h3

// Reset values
`define PIC_RST_MODE 3'h0
`define PIC_RST_FMT 2'h3
`define PIC_RST_COUNT 16'h0000
`define PIC_RST_BYTE 8'h00
`define PIC_ONE 16'h0001

// Synchroniser layout and reset image (strobes idle high)
`define PIC_SYNC_W 21
`define PIC_SYNC_RST 21'h000018

`endif
